// ===== verilog/ssf_spi_flags.sv
// What this block does
// RULE_01: shifter empty flag rises once idle, no pending transmit, no receive.
// RULE_02: shifter empty flag drops when a byte loads or unloads the shifter.
// RULE_03: transfer done flag set by hardware at end of each byte.
// RULE_04: interrupt request raised when transfer done flag sets and enabled.
// RULE_05: hardware never clears transfer done; software writes zero to clear.
// RULE_06: data write while transmit buffer full sets sticky collision, ignored.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module ssf_spi_flags #(
  parameter int HALF_CYC = ssf_pkg::SCK_HALF_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  output logic            irq,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_b,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe_b,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe_b,
  input  wire logic       nss_b
);
  localparam int DIV_W = 8;

  logic [3:0]                  pins_s;
  logic                        sck_s;
  logic                        mosi_s;
  logic                        miso_s;
  logic                        nss_s_b;
  ssf_pkg::ssf_state_t         state;
  ssf_pkg::ssf_state_t         next_state;
  logic [7:0]                  shift, next_shift;
  logic [3:0]                  bit_cnt, next_bit_cnt;
  logic [DIV_W-1:0]            div_cnt, next_div_cnt;
  logic [7:0]                  tx_buf, next_tx_buf;
  logic                        tx_full, next_tx_full;
  logic [7:0]                  rx_buf, next_rx_buf;
  logic                        rx_full, next_rx_full;
  logic                        shifter_empty_flag, next_shifter_empty_flag;
  logic                        transfer_done_flag, next_transfer_done_flag;
  logic                        write_collision_flag;
  logic                        next_write_collision_flag;
  logic                        en, next_en;
  logic                        mst, next_mst;
  logic [ssf_pkg::INT_W-1:0]   istat, next_istat;
  logic [ssf_pkg::INT_W-1:0]   imask, next_imask;
  logic [7:0]                  next_rdata;
  logic                        next_irq;
  logic                        next_sck_out, next_sck_oe_b;
  logic                        next_mosi_out, next_mosi_oe_b;
  logic                        next_miso_out, next_miso_oe_b;
  logic                        sck_d, nss_d_b;

  ssf_sync #(
    .WIDTH (4)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .din     ({nss_b, miso_in, mosi_in, sck_in}),
    .dout    (pins_s)
  );

  assign sck_s   = pins_s[0];
  assign mosi_s  = pins_s[1];
  assign miso_s  = pins_s[2];
  assign nss_s_b = pins_s[3];

  always_comb begin
    logic       done_ev;
    logic       write_collision_flag_ev;
    logic       load;
    logic       finish;
    logic [7:0] in_byte;
    done_ev   = 1'b0;
    write_collision_flag_ev   = 1'b0;
    load      = 1'b0;
    finish    = 1'b0;
    in_byte   = shift;
    next_state   = state;
    next_shift   = shift;
    next_bit_cnt = bit_cnt;
    next_div_cnt = div_cnt;
    next_tx_buf  = tx_buf;
    next_tx_full = tx_full;
    next_rx_buf  = rx_buf;
    next_rx_full = rx_full;
    next_shifter_empty_flag   = shifter_empty_flag;
    next_transfer_done_flag   = transfer_done_flag;
    next_write_collision_flag = write_collision_flag;
    next_en       = en;
    next_mst      = mst;
    next_istat    = istat;
    next_imask    = imask;
    next_rdata    = ssf_pkg::BYTE_RST;
    next_sck_out  = sck_out;
    next_mosi_out = mosi_out;
    next_miso_out = miso_out;

    if (wr_stb) begin
      unique case (addr)
        ssf_pkg::CTRL_ADDR: begin
          next_en = wdata[ssf_pkg::CTRL_EN_BIT];
          // RULE_05: software zero clears
          if (!wdata[ssf_pkg::CTRL_DONE_BIT])
            next_transfer_done_flag = 1'b0;
          if (!wdata[ssf_pkg::CTRL_WRITE_COLLISION_FLAG_BIT])
            next_write_collision_flag = 1'b0;
        end
        ssf_pkg::CFG_ADDR:   next_mst = wdata[ssf_pkg::CFG_MST_BIT];
        ssf_pkg::DATA_ADDR: begin
          // RULE_06: collision on full buffer
          if (tx_full) begin
            write_collision_flag_ev = 1'b1;
          end else begin
            next_tx_buf  = wdata;
            next_tx_full = 1'b1;
          end
        end
        ssf_pkg::ISTAT_ADDR: next_istat = istat & ~wdata[ssf_pkg::INT_W-1:0];
        ssf_pkg::IMASK_ADDR: next_imask = wdata[ssf_pkg::INT_W-1:0];
        default: ;
      endcase
    end

    if (rd_stb) begin
      unique case (addr)
        ssf_pkg::CTRL_ADDR: begin
          next_rdata[ssf_pkg::CTRL_DONE_BIT] = transfer_done_flag;
          next_rdata[ssf_pkg::CTRL_WRITE_COLLISION_FLAG_BIT] = write_collision_flag;
          next_rdata[ssf_pkg::CTRL_TXE_BIT]  = ~tx_full;
          next_rdata[ssf_pkg::CTRL_EN_BIT]   = en;
        end
        ssf_pkg::CFG_ADDR: begin
          next_rdata[ssf_pkg::CFG_BUSY_BIT] = (state == ssf_pkg::SSF_SHIFT);
          next_rdata[ssf_pkg::CFG_MST_BIT]  = mst;
          next_rdata[ssf_pkg::CFG_SHIFTER_EMPTY_FLAG_BIT] = shifter_empty_flag;
          next_rdata[ssf_pkg::CFG_RXE_BIT]  = ~rx_full;
        end
        ssf_pkg::DATA_ADDR: begin
          next_rdata   = rx_buf;
          next_rx_full = 1'b0;
        end
        ssf_pkg::ISTAT_ADDR: next_rdata[ssf_pkg::INT_W-1:0] = istat;
        ssf_pkg::IMASK_ADDR: next_rdata[ssf_pkg::INT_W-1:0] = imask;
        default: ;
      endcase
    end

    unique case (state)
      ssf_pkg::SSF_IDLE: begin
        next_div_cnt = '0;
        next_bit_cnt = '0;
        next_sck_out = 1'b0;
        if (en && mst && tx_full)
          load = 1'b1;
        else if (en && !mst && !nss_s_b && nss_d_b)
          load = 1'b1;
        // RULE_01: idle with nothing pending
        else
          next_shifter_empty_flag = ~tx_full;
      end
      ssf_pkg::SSF_SHIFT: begin
        if (!en || (!mst && nss_s_b)) begin
          next_state   = ssf_pkg::SSF_IDLE;
          next_sck_out = 1'b0;
        end else if (mst) begin
          if (div_cnt == DIV_W'(HALF_CYC - 1)) begin
            next_div_cnt = '0;
            next_sck_out = ~sck_out;
            if (!sck_out) begin
              next_shift   = {shift[6:0], miso_s};
              next_bit_cnt = bit_cnt + 4'h1;
            end else if (bit_cnt == ssf_pkg::BITS_PER_BYTE) begin
              finish     = 1'b1;
              next_state = ssf_pkg::SSF_IDLE;
            end else begin
              next_mosi_out = shift[7];
            end
          end else begin
            next_div_cnt = div_cnt + DIV_W'(1);
          end
        end else begin
          if (sck_s && !sck_d) begin
            in_byte      = {shift[6:0], mosi_s};
            next_shift   = in_byte;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == ssf_pkg::BITS_PER_BYTE - 4'h1) begin
              finish = 1'b1;
              load   = 1'b1;
            end
          end else if (!sck_s && sck_d) begin
            next_miso_out = shift[7];
          end
        end
      end
    endcase

    // RULE_02: shifter unloads into receive buffer
    if (finish) begin
      next_rx_buf  = in_byte;
      next_rx_full = 1'b1;
      next_shifter_empty_flag = 1'b0;
      done_ev = 1'b1;
    end

    // RULE_02: transmit byte loads the shifter
    if (load) begin
      next_state   = ssf_pkg::SSF_SHIFT;
      next_shift   = tx_full ? tx_buf : ssf_pkg::BYTE_RST;
      next_tx_full = next_tx_full & ~tx_full;
      next_bit_cnt = '0;
      next_div_cnt = '0;
      next_shifter_empty_flag = 1'b0;
      next_mosi_out = tx_full & tx_buf[7];
      next_miso_out = tx_full & tx_buf[7];
    end

    // RULE_03: done set wins over clear
    if (done_ev)
      next_transfer_done_flag = 1'b1;
    if (write_collision_flag_ev)
      next_write_collision_flag = 1'b1;
    next_istat[ssf_pkg::INT_DONE_BIT] = next_istat[ssf_pkg::INT_DONE_BIT] |
                                        done_ev;
    next_istat[ssf_pkg::INT_WRITE_COLLISION_FLAG_BIT] = next_istat[ssf_pkg::INT_WRITE_COLLISION_FLAG_BIT] |
                                        write_collision_flag_ev;
    // RULE_04: unmasked event raises request
    next_irq = |(next_istat & next_imask);

    next_sck_oe_b  = ~(next_en & next_mst);
    next_mosi_oe_b = ~(next_en & next_mst);
    next_miso_oe_b = ~(next_en & ~next_mst & ~nss_s_b);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= ssf_pkg::SSF_IDLE;
      shift   <= ssf_pkg::BYTE_RST;
      bit_cnt <= 4'h0;
      div_cnt <= '0;
      tx_buf  <= ssf_pkg::BYTE_RST;
      tx_full <= 1'b0;
      rx_buf  <= ssf_pkg::BYTE_RST;
      rx_full <= 1'b0;
      shifter_empty_flag   <= ssf_pkg::SHIFTER_EMPTY_FLAG_RST;
      transfer_done_flag   <= 1'b0;
      write_collision_flag <= 1'b0;
      en        <= ssf_pkg::EN_RST;
      mst       <= ssf_pkg::MST_RST;
      istat     <= '0;
      imask     <= ssf_pkg::IMASK_RST;
      rdata     <= ssf_pkg::BYTE_RST;
      irq       <= 1'b0;
      sck_out   <= 1'b0;
      sck_oe_b  <= 1'b1;
      mosi_out  <= 1'b0;
      mosi_oe_b <= 1'b1;
      miso_out  <= 1'b0;
      miso_oe_b <= 1'b1;
      sck_d     <= 1'b0;
      nss_d_b   <= 1'b1;
    end else begin
      state   <= next_state;
      shift   <= next_shift;
      bit_cnt <= next_bit_cnt;
      div_cnt <= next_div_cnt;
      tx_buf  <= next_tx_buf;
      tx_full <= next_tx_full;
      rx_buf  <= next_rx_buf;
      rx_full <= next_rx_full;
      shifter_empty_flag   <= next_shifter_empty_flag;
      transfer_done_flag   <= next_transfer_done_flag;
      write_collision_flag <= next_write_collision_flag;
      en        <= next_en;
      mst       <= next_mst;
      istat     <= next_istat;
      imask     <= next_imask;
      rdata     <= next_rdata;
      irq       <= next_irq;
      sck_out   <= next_sck_out;
      sck_oe_b  <= next_sck_oe_b;
      mosi_out  <= next_mosi_out;
      mosi_oe_b <= next_mosi_oe_b;
      miso_out  <= next_miso_out;
      miso_oe_b <= next_miso_oe_b;
      sck_d     <= sck_s;
      nss_d_b   <= nss_s_b;
    end
  end
endmodule

// ===== verilog/ssf_pkg.sv
package ssf_pkg;

  // register addresses on the strobed register port
  localparam logic [7:0] CTRL_ADDR  = 8'hF8;
  localparam logic [7:0] CFG_ADDR   = 8'hA1;
  localparam logic [7:0] DATA_ADDR  = 8'hA3;
  localparam logic [7:0] ISTAT_ADDR = 8'hF0;
  localparam logic [7:0] IMASK_ADDR = 8'hF1;

  // spi_control_status fields
  localparam int CTRL_DONE_BIT = 7;
  localparam int CTRL_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int CTRL_TXE_BIT  = 1;
  localparam int CTRL_EN_BIT   = 0;

  // spi_configuration fields
  localparam int CFG_BUSY_BIT = 7;
  localparam int CFG_MST_BIT  = 6;
  localparam int CFG_SHIFTER_EMPTY_FLAG_BIT = 1;
  localparam int CFG_RXE_BIT  = 0;

  // interrupt status and mask fields
  localparam int INT_DONE_BIT = 0;
  localparam int INT_WRITE_COLLISION_FLAG_BIT = 1;
  localparam int INT_W        = 2;

  // reset values
  localparam logic             EN_RST    = 1'b0;
  localparam logic             MST_RST   = 1'b0;
  localparam logic             SHIFTER_EMPTY_FLAG_RST  = 1'b1;
  localparam logic [INT_W-1:0] IMASK_RST = 2'h0;
  localparam logic [7:0]       BYTE_RST  = 8'h00;

  // master clock half period
  localparam int CLK_NS       = 20;
  localparam int SCK_HALF_NS  = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic {SSF_IDLE, SSF_SHIFT} ssf_state_t;

endpackage

// ===== verilog/ssf_sync.sv
`timescale 1ns/100ps
module ssf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ===== sim/ssf_spi_flags_chk.sv
`timescale 1ns/100ps
module ssf_spi_flags_chk (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [7:0] addr,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  input wire logic       sck_out,
  input wire logic       sck_oe_b,
  input wire logic       mosi_out,
  input wire logic       mosi_oe_b,
  input wire logic       miso_oe_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  chk_rdata_zero: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_unmapped_read: assert property (
    $past(rd_stb) && $past(addr) == 8'h00 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_irq_fall_write: assert property (
    $fell(irq) |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("interrupt dropped without a write");
  chk_irq_rise_cause: assert property (
    $rose(irq) |-> $past(wr_stb) || $past(wr_stb, 2) || $past(wr_stb, 3)
      || !$past(sck_oe_b, 2) || !$past(miso_oe_b, 2))
    else $error("interrupt rose without a cause");
  chk_oe_pair: assert property (mosi_oe_b == sck_oe_b)
    else $error("data and clock enables differ");
  chk_mosi_shift_low: assert property (
    $changed(mosi_out) && !mosi_oe_b |-> !sck_out)
    else $error("data out changed while clock high");
endmodule

bind ssf_spi_flags ssf_spi_flags_chk u_chk (
  .sys_clk   (sys_clk),
  .rst_b     (rst_b),
  .addr      (addr),
  .wr_stb    (wr_stb),
  .rd_stb    (rd_stb),
  .rdata     (rdata),
  .irq       (irq),
  .sck_out   (sck_out),
  .sck_oe_b  (sck_oe_b),
  .mosi_out  (mosi_out),
  .mosi_oe_b (mosi_oe_b),
  .miso_oe_b (miso_oe_b)
);

// ===== sim/ssf_spi_peer.sv
`timescale 1ns/100ps
module ssf_spi_peer (
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso
);
  logic [7:0] rx_byte;
  logic [7:0] tx_sh;
  int         n;

  task automatic load(input logic [7:0] b);
    tx_sh = b;
    n = 0;
    miso = b[7];
  endtask

  initial begin
    rx_byte = 8'h00;
    tx_sh = 8'h00;
    n = 8;
    miso = 1'b0;
  end
  // sample on rise, msb first
  always @(posedge sck) begin
    rx_byte = {rx_byte[6:0], mosi};
    n = n + 1;
  end
  // shift on fall; after the eighth bit the line toggles on each fall
  always @(negedge sck) begin
    if (n < 8)
      miso = tx_sh[7 - n];
    else
      miso = ~miso;
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic       sys_clk;
  logic       rst_b;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic       irq;
  logic       sck_out;
  logic       mosi_out;
  logic       miso_in;
  logic       sck_in;
  logic       mosi_in;
  logic       nss_b;
  logic       miso_out;
  logic [7:0] got;
  logic [7:0] v;
  int         mismatches;
  int         checked;

  ssf_spi_flags dut (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .addr      (addr),
    .wdata     (wdata),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb),
    .rdata     (rdata),
    .irq       (irq),
    .sck_in    (sck_in),
    .sck_out   (sck_out),
    .sck_oe_b  (),
    .mosi_in   (mosi_in),
    .mosi_out  (mosi_out),
    .mosi_oe_b (),
    .miso_in   (miso_in),
    .miso_out  (miso_out),
    .miso_oe_b (),
    .nss_b     (nss_b)
  );
  ssf_spi_peer peer (.sck(sck_out), .mosi(mosi_out), .miso(miso_in));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, d, input bit hold = 0);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    if (!hold) begin
      wr_stb <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
    @(posedge sys_clk);
  endtask

  task automatic rbit(input logic [7:0] a, input int b, input logic e,
                      input string n);
    rd(a, v);
    chk(n, {7'h00, v[b]}, {7'h00, e});
  endtask

  task automatic poll(input logic [7:0] a, input int b);
    repeat (200) begin
      rd(a, v);
      if (v[b] === 1'b1)
        return;
    end
    mismatches++;
    stop_test();
  endtask

  // far master: one mode 0 byte, sck period 8 clocks, miso taken at rise
  task automatic slave_byte(input logic [7:0] b);
    nss_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= b[i];
      repeat (4) @(posedge sys_clk);
      got = {got[6:0], miso_out};
      sck_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sck_in <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    nss_b <= 1'b1;
    @(posedge sys_clk);
  endtask

  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    sck_in = 1'b0;
    mosi_in = 1'b0;
    nss_b = 1'b1;
    got = 8'h00;
    mismatches = 0;
    checked = 0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rbit(ssf_pkg::CFG_ADDR, ssf_pkg::CFG_SHIFTER_EMPTY_FLAG_BIT, 1'b1, "shifter_empty_flag_rst");
    wr(8'h00, 8'hFF);
    rd(8'h00, v);
    chk("unmapped", v, 8'h00);
    wr(ssf_pkg::IMASK_ADDR, 8'h03);
    wr(ssf_pkg::CFG_ADDR, 8'h40);
    wr(ssf_pkg::CTRL_ADDR, 8'h01);
    // master byte: flags around one transfer
    peer.load(8'h3C);
    wr(ssf_pkg::DATA_ADDR, 8'hA5);
    repeat (2) @(posedge sys_clk);
    rbit(ssf_pkg::CFG_ADDR, ssf_pkg::CFG_SHIFTER_EMPTY_FLAG_BIT, 1'b0, "shifter_empty_flag_busy");
    poll(ssf_pkg::CTRL_ADDR, ssf_pkg::CTRL_DONE_BIT);
    chk("irq_done", {7'h00, irq}, 8'h01);
    rd(ssf_pkg::DATA_ADDR, v);
    chk("rx_byte", v, 8'h3C);
    chk("peer_rx", peer.rx_byte, 8'hA5);
    rbit(ssf_pkg::CFG_ADDR, ssf_pkg::CFG_SHIFTER_EMPTY_FLAG_BIT, 1'b1, "shifter_empty_flag_idle");
    rd(ssf_pkg::ISTAT_ADDR, v);
    chk("istat_done", v, 8'h01);
    // done stays until software clears it
    repeat (40) @(posedge sys_clk);
    wr(ssf_pkg::CTRL_ADDR, 8'h81);
    wr(ssf_pkg::IMASK_ADDR, 8'h00);
    rbit(ssf_pkg::CTRL_ADDR, ssf_pkg::CTRL_DONE_BIT, 1'b1, "sticky");
    chk("irq_masked", {7'h00, irq}, 8'h00);
    wr(ssf_pkg::IMASK_ADDR, 8'h03);
    rd(ssf_pkg::ISTAT_ADDR, v);
    chk("irq_unmask", {7'h00, irq}, 8'h01);
    wr(ssf_pkg::CTRL_ADDR, 8'h01);
    wr(ssf_pkg::ISTAT_ADDR, 8'h01);
    rbit(ssf_pkg::CTRL_ADDR, ssf_pkg::CTRL_DONE_BIT, 1'b0, "cleared");
    chk("irq_clear", {7'h00, irq}, 8'h00);
    // collision: third write while the transmit buffer is full
    peer.load(8'h5A);
    wr(ssf_pkg::DATA_ADDR, 8'h11);
    repeat (3) @(posedge sys_clk);
    wr(ssf_pkg::DATA_ADDR, 8'h22, 1);
    wr(ssf_pkg::DATA_ADDR, 8'h33);
    rbit(ssf_pkg::CTRL_ADDR, ssf_pkg::CTRL_WRITE_COLLISION_FLAG_BIT, 1'b1, "write_collision_flag");
    chk("irq_write_collision_flag", {7'h00, irq}, 8'h01);
    rd(ssf_pkg::ISTAT_ADDR, v);
    chk("istat_write_collision_flag", v, 8'h02);
    poll(ssf_pkg::CTRL_ADDR, ssf_pkg::CTRL_DONE_BIT);
    wr(ssf_pkg::CTRL_ADDR, 8'h41);
    poll(ssf_pkg::CTRL_ADDR, ssf_pkg::CTRL_DONE_BIT);
    chk("peer_rx2", peer.rx_byte, 8'h22);
    // slave byte: done also set when the far master clocks
    wr(ssf_pkg::CTRL_ADDR, 8'h01);
    wr(ssf_pkg::ISTAT_ADDR, 8'h03);
    wr(ssf_pkg::CFG_ADDR, 8'h00);
    wr(ssf_pkg::DATA_ADDR, 8'h96);
    chk("irq_idle", {7'h00, irq}, 8'h00);
    slave_byte(8'hC3);
    poll(ssf_pkg::CTRL_ADDR, ssf_pkg::CTRL_DONE_BIT);
    chk("irq_slave", {7'h00, irq}, 8'h01);
    rd(ssf_pkg::DATA_ADDR, v);
    chk("slave_rx", v, 8'hC3);
    chk("slave_tx", got, 8'h96);
    stop_test();
  end
endmodule
